// >>> npi_pkg.sv
// shared constants and carrier types for the nested priority interrupt unit
package npi_pkg;
   localparam int NPI_NSRC = 7;
   localparam int NPI_IDX_W = 3;
   localparam int NPI_PRIO_W = 3;
   localparam int NPI_TYPE_W = 5;
   localparam int NPI_POLL_W = 16;
   localparam int NPI_POLL_PEND_BIT = 15;
   localparam int NPI_N_TMR = 3;
   localparam int NPI_N_DMA = 2;
   localparam int NPI_N_EXT = 4;
   localparam int NPI_N_CASC = 2;
   // source order, also the tie-break order (lower index wins)
   localparam logic [2:0] NPI_SRC_TMR = 3'h0;
   localparam logic [2:0] NPI_SRC_DMA0 = 3'h1;
   localparam logic [2:0] NPI_SRC_DMA1 = 3'h2;
   localparam logic [2:0] NPI_SRC_EXT0 = 3'h3;
   localparam int NPI_EXT_BASE = 3;
   // fixed vector types per source, index 0 in the low slice
   localparam logic [6:0][4:0] NPI_VEC_TYPE = {5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h08};
   localparam logic [4:0] NPI_SPURIOUS_TYPE = 5'h07;
   localparam logic [2:0] NPI_PRIO_LOWEST = 3'h7;
   localparam logic [15:0] NPI_POLL_RST = 16'h0000;
   localparam logic [6:0] NPI_IS_RST = 7'h00;

   typedef struct packed {
      logic [6:0] mask;
      logic [6:0][2:0] level;
      logic [2:0] prio_mask;
      logic [1:0] cascade;
      logic [1:0] special_nesting_bit;
      logic [3:0] level_trigger;
      logic slave_mode;
   } npi_cfg_type;

   typedef struct packed {
      logic rd_poll;
      logic rd_poll_status;
      logic end_of_service_cmd;
      logic eos_specific;
      logic [4:0] eos_type;
   } npi_cmd_type;
endpackage

// >>> npi_prio_pick.sv
// picks the highest-priority valid entry: lowest level, then lowest index
`timescale 1ns/1ns
module npi_prio_pick #(
   parameter int N = 7,
   parameter int IW = 3,
   parameter int LW = 3
) (
   // candidates
   input wire logic [N-1:0] i_valid,
   input wire logic [N-1:0][LW-1:0] i_level,
   // winner
   output logic o_found,
   output logic [IW-1:0] o_idx,
   output logic [LW-1:0] o_level
);
   always_comb begin
      o_found = 1'b0;
      o_idx = '0;
      o_level = '1;
      // walk downward so that on equal levels the lower index is taken last
      for (int i = N - 1; i >= 0; i--) begin
         if (i_valid[i] && (!o_found || i_level[i] <= o_level)) begin
            o_found = 1'b1;
            o_idx = IW'(i);
            o_level = i_level[i];
         end
      end
   end
endmodule

// >>> npi_core.sv
// nested priority interrupt unit, master mode, with direct/cascade/special nesting pins
`timescale 1ns/1ns
module npi_core (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // internal sources with their own enables
   input wire logic [npi_pkg::NPI_N_TMR-1:0] i_timer_req,
   input wire logic [npi_pkg::NPI_N_TMR-1:0] i_timer_en,
   input wire logic [npi_pkg::NPI_N_DMA-1:0] i_dma_req,
   input wire logic [npi_pkg::NPI_N_DMA-1:0] i_dma_en,
   // external pins
   input wire logic [npi_pkg::NPI_N_EXT-1:0] i_ext_request,
   input wire logic i_nmi_pin,
   // configuration
   input wire npi_pkg::npi_cfg_type i_cfg,
   // cpu side
   input wire logic i_vector_fetch_cycle,
   input wire npi_pkg::npi_cmd_type i_cmd,
   output logic o_int,
   output logic o_nmi,
   output logic [npi_pkg::NPI_TYPE_W-1:0] o_vector,
   output logic o_vector_valid,
   output logic o_vector_external,
   output logic [npi_pkg::NPI_POLL_W-1:0] o_poll_word,
   // status
   output logic [npi_pkg::NPI_NSRC-1:0] o_in_service,
   output logic [npi_pkg::NPI_NSRC-1:0] o_request,
   output logic o_slave_mode,
   // cascade acknowledge drive on pins 2 and 3 (active low level)
   output logic [npi_pkg::NPI_N_CASC-1:0] o_cascade_ack_out,
   output logic [npi_pkg::NPI_N_CASC-1:0] o_cascade_ack_oe
);
   localparam int NS = npi_pkg::NPI_NSRC;
   localparam int IW = npi_pkg::NPI_IDX_W;
   localparam int LW = npi_pkg::NPI_PRIO_W;

   typedef enum logic [0:0] {FS_IDLE, FS_SECOND} npi_fetch_type;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   npi_fetch_type fetch_r;
   logic [NS-1:0] in_service_r;
   logic [npi_pkg::NPI_N_DMA:0] int_req_r;
   logic [npi_pkg::NPI_N_EXT-1:0] ext_armed_r;
   logic nmi_prev_r;
   logic [IW-1:0] ack_idx_r;
   logic ack_found_r;
   logic [NS-1:0] casc_src;
   logic [NS-1:0] special_nesting_bit_src;
   logic [NS-1:0] pending;
   logic [NS-1:0] eligible;
   logic [NS-1:0] ext_used;
   logic win_found;
   logic [IW-1:0] win_idx;
   logic [LW-1:0] win_level;
   logic is_found;
   logic [IW-1:0] is_idx;
   logic [LW-1:0] is_level;
   logic int_cond;
   logic fetch_first;
   logic take;
   logic [NS-1:0] is_set;
   logic [NS-1:0] is_clr;
   logic [npi_pkg::NPI_N_DMA:0] int_new;

   ////////////////////////////////////////////////////////////////////////////
   // source requests
   assign o_slave_mode = i_cfg.slave_mode;

   // internal requests latched here; cascade choice never touches them
   assign int_new = {i_dma_req & i_dma_en, |(i_timer_req & i_timer_en)};

   // pin k and pin k+2 form cascade pair k, each pair chosen on its own
   assign casc_src = {2'b00, i_cfg.cascade, 3'b000};
   assign special_nesting_bit_src = {2'b00, i_cfg.special_nesting_bit & i_cfg.cascade, 3'b000};
   assign ext_used = {~i_cfg.cascade, 2'b11, 3'b111};

   generate
      for (genvar e = 0; e < npi_pkg::NPI_N_EXT; e++) begin : g_ext
         // edge mode needs the pin low for a clock after acknowledge to re-arm
         assign pending[npi_pkg::NPI_EXT_BASE + e] = ext_used[npi_pkg::NPI_EXT_BASE + e]
            & i_ext_request[e] & (i_cfg.level_trigger[e] | ext_armed_r[e]);
      end
   endgenerate
   assign pending[npi_pkg::NPI_EXT_BASE-1:0] = int_req_r;
   assign o_request = pending;

   ////////////////////////////////////////////////////////////////////////////
   // priority resolution
   generate
      for (genvar s = 0; s < NS; s++) begin : g_elig
         // own flag blocks a repeat unless special nesting is on for that pin
         assign eligible[s] = pending[s] & ~i_cfg.mask[s]
            & (i_cfg.level[s] <= i_cfg.prio_mask)
            & (~in_service_r[s] | special_nesting_bit_src[s]);
      end
   endgenerate

   npi_prio_pick #(.N(NS), .IW(IW), .LW(LW)) u_req_pick (
      .i_valid(eligible),
      .i_level(i_cfg.level),
      .o_found(win_found),
      .o_idx(win_idx),
      .o_level(win_level)
   );

   npi_prio_pick #(.N(NS), .IW(IW), .LW(LW)) u_is_pick (
      .i_valid(in_service_r),
      .i_level(i_cfg.level),
      .o_found(is_found),
      .o_idx(is_idx),
      .o_level(is_level)
   );

   // a request must beat the top active flag; equal level falls to source order
   always_comb begin
      int_cond = 1'b0;
      if (win_found && !i_cfg.slave_mode) begin
         if (!is_found) begin
            int_cond = 1'b1;
         end else if (win_level < is_level) begin
            int_cond = 1'b1;
         end else if (win_level == is_level && win_idx < is_idx) begin
            int_cond = 1'b1;
         end else if (win_idx == is_idx && special_nesting_bit_src[win_idx]) begin
            int_cond = 1'b1;
         end
      end
   end
   assign o_int = int_cond;

   ////////////////////////////////////////////////////////////////////////////
   // acknowledge, poll and end-of-service
   assign fetch_first = i_vector_fetch_cycle && fetch_r == FS_IDLE;
   assign take = (fetch_first | i_cmd.rd_poll) & int_cond;

   generate
      for (genvar s = 0; s < NS; s++) begin : g_is
         assign is_set[s] = take && win_idx == IW'(s);
         assign is_clr[s] = i_cmd.end_of_service_cmd && (i_cmd.eos_specific
            ? i_cmd.eos_type == npi_pkg::NPI_VEC_TYPE[s]
            : is_found && is_idx == IW'(s));
      end
   endgenerate

   // a set in the same cycle as a clear wins
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         in_service_r <= npi_pkg::NPI_IS_RST;
      end else begin
         in_service_r <= is_set | (in_service_r & ~is_clr);
      end
   end
   assign o_in_service = in_service_r;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         int_req_r <= '0;
      end else begin
         // new request beats the acknowledge clear
         int_req_r <= int_new | (int_req_r & ~is_set[npi_pkg::NPI_EXT_BASE-1:0]);
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ext_armed_r <= '0;
      end else begin
         for (int e = 0; e < npi_pkg::NPI_N_EXT; e++) begin
            if (!i_ext_request[e]) begin
               ext_armed_r[e] <= 1'b1;
            end else if (is_set[npi_pkg::NPI_EXT_BASE + e]) begin
               ext_armed_r[e] <= 1'b0;
            end
         end
      end
   end

   // two fetch cycles: first picks and flags the source, second hands the vector
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fetch_r <= FS_IDLE;
         ack_idx_r <= '0;
         ack_found_r <= 1'b0;
      end else begin
         case (fetch_r)
            FS_IDLE: begin
               if (i_vector_fetch_cycle) begin
                  fetch_r <= FS_SECOND;
                  ack_idx_r <= win_idx;
                  ack_found_r <= int_cond;
               end
            end
            FS_SECOND: begin
               if (i_vector_fetch_cycle) begin
                  fetch_r <= FS_IDLE;
               end
            end
            default: begin
               fetch_r <= FS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_vector <= '0;
         o_vector_valid <= 1'b0;
         o_vector_external <= 1'b0;
      end else begin
         o_vector_valid <= 1'b0;
         if (fetch_r == FS_SECOND && i_vector_fetch_cycle) begin
            o_vector_valid <= 1'b1;
            // cascade sources leave the vector to the external controller
            o_vector_external <= ack_found_r && casc_src[ack_idx_r];
            o_vector <= ack_found_r ? npi_pkg::NPI_VEC_TYPE[ack_idx_r]
                                    : npi_pkg::NPI_SPURIOUS_TYPE;
         end
      end
   end

   // acknowledge strobe covers both fetch cycles of a cascade source
   generate
      for (genvar k = 0; k < npi_pkg::NPI_N_CASC; k++) begin : g_ack
         localparam int SRC = npi_pkg::NPI_EXT_BASE + k;
         assign o_cascade_ack_oe[k] = i_cfg.cascade[k];
         assign o_cascade_ack_out[k] = ~(i_cfg.cascade[k] & i_vector_fetch_cycle
            & ((fetch_first & int_cond & win_idx == IW'(SRC))
             | (fetch_r == FS_SECOND & ack_found_r & ack_idx_r == IW'(SRC))));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // poll words and non-maskable pin
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_poll_word <= npi_pkg::NPI_POLL_RST;
      end else if (i_cmd.rd_poll || i_cmd.rd_poll_status) begin
         // status read shows the same word but leaves the flags alone
         o_poll_word <= npi_pkg::NPI_POLL_RST;
         o_poll_word[npi_pkg::NPI_POLL_PEND_BIT] <= int_cond;
         o_poll_word[npi_pkg::NPI_TYPE_W-1:0] <= npi_pkg::NPI_VEC_TYPE[win_idx];
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         nmi_prev_r <= 1'b0;
         o_nmi <= 1'b0;
      end else begin
         nmi_prev_r <= i_nmi_pin;
         // no mask, level or flag gates this path
         o_nmi <= i_nmi_pin & ~nmi_prev_r;
      end
   end
endmodule

// >>> npi_core_assertions.sv
// port checker for the nested priority interrupt unit
`timescale 1ns/1ns
module npi_core_chk (
   // clock, reset and watched inputs
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_nmi_pin,
   input wire npi_pkg::npi_cfg_type i_cfg,
   input wire logic i_vector_fetch_cycle,
   input wire npi_pkg::npi_cmd_type i_cmd,
   // watched outputs
   input wire logic o_int,
   input wire logic o_nmi,
   input wire logic o_vector_valid,
   input wire logic [6:0] o_in_service,
   input wire logic [6:0] o_request,
   input wire logic [1:0] o_cascade_ack_out,
   input wire logic [1:0] o_cascade_ack_oe
);
   logic second_r;
   // fetch pulses come in pairs, the second one ends the sequence
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         second_r <= 1'b0;
      end else if (i_vector_fetch_cycle) begin
         second_r <= !second_r;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////////////
   nmi_follow_a: assert property ($rose(i_nmi_pin) |-> ##[1:2] o_nmi)
      else $error("nmi edge gave no pulse");
   slave_block_a: assert property (i_cfg.slave_mode |-> !o_int)
      else $error("interrupt raised in slave mode");
   mask_all_a: assert property (&i_cfg.mask |-> !o_int)
      else $error("interrupt raised with all masked");
   int_cause_a: assert property (o_int |-> |o_request)
      else $error("interrupt without request");
   ack_oe_a: assert property (o_cascade_ack_oe == i_cfg.cascade)
      else $error("ack enable differs from pair mode");
   ack_idle_a: assert property (o_cascade_ack_oe[0] && !i_vector_fetch_cycle |-> o_cascade_ack_out[0])
      else $error("ack driven low outside fetch");
   valid_second_a: assert property (i_vector_fetch_cycle |=> o_vector_valid == $past(second_r))
      else $error("vector valid not after second fetch");
   status_keep_a: assert property (i_cmd.rd_poll_status && !i_cmd.rd_poll && !i_vector_fetch_cycle
      && !i_cmd.end_of_service_cmd |=> $stable(o_in_service))
      else $error("status read changed flags");
   eos_one_a: assert property (i_cmd.end_of_service_cmd && !i_cmd.eos_specific && |o_in_service
      && !i_vector_fetch_cycle && !i_cmd.rd_poll
      |=> $countones(o_in_service) + 1 == $countones($past(o_in_service)))
      else $error("end of service did not clear one flag");
   cover property (o_vector_valid);
   cover property (o_nmi);
   cover property (o_cascade_ack_oe[0] && !o_cascade_ack_out[0]);
endmodule
bind npi_core npi_core_chk u_chk (.i_clk, .i_reset, .i_nmi_pin, .i_cfg, .i_vector_fetch_cycle,
   .i_cmd, .o_int, .o_nmi, .o_vector_valid, .o_in_service, .o_request, .o_cascade_ack_out,
   .o_cascade_ack_oe);

// >>> npi_ext_ctrl.sv
// behavioural cascaded controller on request pin 0 and acknowledge pin 2
`timescale 1ns/1ns
module npi_ext_ctrl (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // bench trigger and pin side
   input wire logic i_fire,
   input wire logic i_ack_n,
   output logic o_req
);
   logic acks_r;
   // request held through both acknowledge cycles, dropped after the second
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_req <= 1'b0;
         acks_r <= 1'b0;
      end else if (i_fire) begin
         o_req <= 1'b1;
      end else if (o_req && !i_ack_n) begin
         acks_r <= !acks_r;
         o_req <= !acks_r;
      end
   end
endmodule

// >>> tb.sv
// self-checking bench for the nested priority interrupt unit
`timescale 1ns/1ns
module tb;
   localparam logic [6:0][4:0] vt = npi_pkg::NPI_VEC_TYPE;
   logic i_clk, i_reset, nmi, fetch, fire, ext1, o_int, vvalid, vext, req0, nmi_o, slv;
   logic poll_d = 1'b0;
   logic [2:0] treq, ten, done;
   logic [1:0] dreq, den, ack, oe;
   logic [4:0] vec;
   logic [6:0] isr, e, rq;
   logic [15:0] poll, lfsr;
   logic [6:0] vq[$];
   logic [15:0] pq[$];
   npi_pkg::npi_cfg_type cfg;
   npi_pkg::npi_cmd_type cmd;
   int n_errors = 0, compares = 0, best;
   // idle low so pin 2 requests nothing while it is a direct input
   wire pin2 = oe[0] ? ack[0] : 1'b0;
   npi_core i_dut (.i_clk, .i_reset, .i_timer_req(treq), .i_timer_en(ten), .i_dma_req(dreq),
      .i_dma_en(den), .i_ext_request({1'b0, pin2, ext1, req0}), .i_nmi_pin(nmi), .i_cfg(cfg),
      .i_vector_fetch_cycle(fetch), .i_cmd(cmd), .o_int, .o_nmi(nmi_o), .o_vector(vec),
      .o_vector_valid(vvalid), .o_vector_external(vext), .o_poll_word(poll),
      .o_in_service(isr), .o_request(rq), .o_slave_mode(slv), .o_cascade_ack_out(ack),
      .o_cascade_ack_oe(oe));
   npi_ext_ctrl u_ext (.i_clk, .i_reset, .i_fire(fire), .i_ack_n(pin2), .o_req(req0));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic tick(input int n); repeat (n) @(negedge i_clk); endtask
   task automatic cmp(input logic [15:0] g, input logic [15:0] x);
      compares++;
      if (g !== x) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chk_int(input logic x); cmp({15'h0, o_int}, {15'h0, x}); endtask
   task automatic chk_is(input logic [6:0] x); cmp({9'h0, isr}, {9'h0, x}); endtask
   // bit 6 of a note: vector type comes from the far controller, not checked
   task automatic ack2(input logic [6:0] x);
      vq.push_back(x);
      repeat (2) begin
         fetch = 1'b1;
         tick(1);
         fetch = 1'b0;
         tick(2);
      end
   endtask
   task automatic pulse(input npi_pkg::npi_cmd_type c);
      cmd = c;
      tick(1);
      cmd = '0;
      tick(1);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk) poll_d <= cmd.rd_poll | cmd.rd_poll_status;
   always @(negedge i_clk) begin
      if (vvalid) begin
         e = (vq.size() > 0) ? vq.pop_front() : 7'h1F;
         cmp({10'h0, vext, e[6] ? e[4:0] : vec}, {10'h0, e[5:0]});
      end
      if (poll_d) begin
         cmp(poll, pq.pop_front());
      end
   end
   initial begin
      repeat (3000) @(posedge i_clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      i_reset = 1'b1;
      {nmi, fetch, fire, ext1, treq, dreq, cmd} = '0;
      {ten, den, lfsr} = {5'h1F, 16'hF9A0};
      cfg = '0;
      cfg.prio_mask = 3'h7;
      cfg.level_trigger = 4'hD;
      tick(12);
      i_reset = 1'b0;
      tick(2);
      for (int it = 0; it < 6; it++) begin
         lfsr = lfsr_next(lfsr);
         cfg.level[2:0] = lfsr[8:0];
         {treq, dreq} = 5'h13;
         tick(1);
         {treq, dreq, done} = 8'h00;
         repeat (3) begin
            best = 2;
            for (int s = 1; s >= 0; s--) begin
               if (!done[s] && (done[best] || cfg.level[s] <= cfg.level[best])) best = s;
            end
            done[best] = 1'b1;
            ack2({2'h0, vt[best]});
            chk_int(1'b0);
            pulse(9'h040);
         end
      end
      $display("test priority done");
      cfg.level[1:0] = 6'h15;
      treq = 3'h1;
      tick(1);
      treq = 3'h0;
      ack2({2'h0, vt[0]});
      dreq = 2'h1;
      tick(1);
      dreq = 2'h0;
      chk_int(1'b1);
      ack2({2'h0, vt[1]});
      chk_is(7'h03);
      pulse(9'h040);
      chk_is(7'h01);
      pulse({4'h3, vt[0]});
      chk_is(7'h00);
      $display("test nesting done");
      // a request with its own enable off must never latch
      {den, dreq} = 4'h1;
      tick(1);
      chk_int(1'b0);
      {den, dreq} = 4'hE;
      tick(1);
      dreq = 2'h0;
      cfg.mask = 7'h7F;
      tick(1);
      chk_int(1'b0);
      cmp({9'h0, rq}, 16'h0004);
      cfg.mask = 7'h00;
      cfg.level[2] = 3'h4;
      cfg.prio_mask = 3'h3;
      tick(1);
      chk_int(1'b0);
      cfg.prio_mask = 3'h7;
      cfg.slave_mode = 1'b1;
      tick(1);
      chk_int(1'b0);
      cmp({15'h0, slv}, 16'h0001);
      cfg.slave_mode = 1'b0;
      pq.push_back({11'h400, vt[2]});
      pulse(9'h080);
      chk_is(7'h00);
      pq.push_back({11'h400, vt[2]});
      pulse(9'h100);
      chk_is(7'h04);
      pulse(9'h040);
      $display("test mask and poll done");
      ext1 = 1'b1;
      tick(1);
      ack2({2'h0, vt[4]});
      pulse(9'h040);
      chk_int(1'b0);
      ext1 = 1'b0;
      tick(1);
      ext1 = 1'b1;
      tick(1);
      chk_int(1'b1);
      ext1 = 1'b0;
      $display("test edge done");
      cfg.cascade = 2'h1;
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
      cmp({14'h0, oe}, 16'h0001);
      chk_int(1'b1);
      ack2(7'h60);
      cmp({15'h0, req0}, 16'h0000);
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
      chk_int(1'b0);
      cfg.special_nesting_bit = 2'h1;
      tick(1);
      chk_int(1'b1);
      ack2(7'h60);
      chk_is(7'h08);
      // the far controller has nothing more in service, so the local flag may go
      cmp({15'h0, req0}, 16'h0000);
      pulse({4'h3, vt[3]});
      chk_is(7'h00);
      cfg.cascade = 2'h2;
      ext1 = 1'b1;
      tick(1);
      cmp({14'h0, oe}, 16'h0002);
      ack2(7'h60);
      pulse({4'h3, vt[4]});
      ext1 = 1'b0;
      chk_is(7'h00);
      $display("test cascade done");
      // every mask on: the non-maskable path must still pulse
      cfg.mask = 7'h7F;
      nmi = 1'b1;
      tick(1);
      cmp({15'h0, nmi_o}, 16'h0001);
      tick(1);
      cmp({15'h0, nmi_o}, 16'h0000);
      nmi = 1'b0;
      tick(2);
      $display("test nmi done");
      cmp(16'(vq.size() + pq.size()), 16'h0000);
      end_of_test();
   end
endmodule
